// ===== core/blc_fifo.sv
// Small valid/ready buffer in the output pixel path
`timescale 1ns/10ps
`default_nettype none
module blc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } blc_fifo_t;

  blc_fifo_t q, d;
  logic push, pop;

  assign o_ready = (q.cnt != FULL_CNT);
  assign o_valid = (q.cnt != '0);
  assign o_data = q.mem[q.rd];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = i_data;
      d.wr = (q.wr == LAST_PTR) ? '0 : q.wr + 1'b1;
    end
    if (pop)
      d.rd = (q.rd == LAST_PTR) ? '0 : q.rd + 1'b1;
    if (push && !pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end
endmodule
`default_nettype wire

// ===== core/blc_filter.sv
// Per-path dark sample averaging and shortfall detection
`timescale 1ns/10ps
`default_nettype none
module blc_filter
  import blc_pkg::*;
#(
  parameter int NP = blc_pkg::NPATH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_clr,
  input wire logic i_fin,
  input wire logic [2:0] i_depth,
  // Dark samples
  input wire logic i_smp_valid,
  input wire logic [blc_pkg::COL_W-1:0] i_smp_col,
  input wire logic [blc_pkg::PIX_W-1:0] i_smp_data,
  // Results
  output logic [NP-1:0][blc_pkg::PIX_W-1:0] o_level,
  output logic [NP-1:0] o_short
);
  import blc_pkg::*;

  typedef struct packed {
    logic [NP-1:0][SUM_W-1:0] sum;
    logic [NP-1:0][CNT_W-1:0] cnt;
    logic [NP-1:0][PIX_W-1:0] lvl;
    logic [NP-1:0] shrt;
  } blc_filt_t;

  blc_filt_t q, d;
  logic [CNT_W-1:0] need;
  logic [NP-1:0][SUM_W-1:0] sum_n;
  logic [NP-1:0][CNT_W-1:0] cnt_n;
  logic [NP-1:0][PIX_W-1:0] avg;
  logic [NP-1:0] shrt_n;

  assign need = CNT_W'(1) << i_depth;

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_path
      logic hit;
      logic [SUM_W-1:0] sh;
      // Only the first 2^depth samples count; later ones are ignored
      assign hit = i_smp_valid && (i_smp_col == COL_W'(g)) && (q.cnt[g] < need);
      assign sum_n[g] = i_clr ? '0 : (hit ? q.sum[g] + SUM_W'(i_smp_data) : q.sum[g]);
      assign cnt_n[g] = i_clr ? '0 : (hit ? q.cnt[g] + 1'b1 : q.cnt[g]);
      assign sh = sum_n[g] >> i_depth;
      assign avg[g] = sh[PIX_W-1:0];
      assign shrt_n[g] = (cnt_n[g] < need);
    end
  endgenerate

  always_comb
  begin
    d = q;
    d.sum = sum_n;
    d.cnt = cnt_n;
    if (i_fin)
    begin
      d.lvl = avg;
      d.shrt = shrt_n;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  assign o_level = q.lvl;
  assign o_short = q.shrt;

  a_flag_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_fin |=> $stable(o_short)) else $error("shortfall flags changed outside frame end");
  a_flag_depth0: assert property (@(posedge i_clk) disable iff (i_rst)
    i_fin && i_depth == 3'h0 && i_smp_valid && !i_clr |=> !o_short[$past(i_smp_col)])
    else $error("path with one sample flagged at depth zero");
endmodule
`default_nettype wire

// ===== core/blc_top.sv
// Black-level calibration: dark row sequencing, correction and registers
`timescale 1ns/10ps
`default_nettype none
module blc_top
  import blc_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // Register port
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [blc_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [blc_pkg::REG_W-1:0] I_REG_WDATA,
  output logic [blc_pkg::REG_W-1:0] O_REG_RDATA,
  // Frame timing and readout mode
  input wire logic I_FRAME_START,
  input wire logic I_ROLLING,
  input wire logic [7:0] I_LINE_KERNELS,
  output logic O_DARK_ACTIVE,
  output logic O_DARK_ROW_START,
  // Digitized pixels in
  input wire logic I_PIX_VALID,
  input wire logic [blc_pkg::PIX_W-1:0] I_PIX_DATA,
  output logic O_PIX_READY,
  // Pixels out
  output logic O_PIX_VALID,
  output logic [blc_pkg::PIX_W-1:0] O_PIX_DATA,
  output logic O_PIX_DARK,
  input wire logic I_PIX_READY
);
  import blc_pkg::*;

  localparam int OW = PIX_W + 1;

  typedef struct packed {
    blc_state_t st;
    logic [7:0] row_cnt;
    logic [PCNT_W-1:0] pix_cnt;
    logic [PCNT_W-1:0] row_len;
    logic row_go;
    logic [7:0] rows;
    logic gate;
    logic [2:0] depth;
    logic auto_en;
    logic [8:0] off;
    logic dec;
    logic [REG_W-1:0] rdata;
  } blc_top_t;

  blc_top_t q, d;

  logic buf_ready;
  logic accept;
  logic last_pix;
  logic last_row;
  logic dropping;
  logic in_dark;
  logic smp_valid;
  logic fin;
  logic push_valid;
  logic [PIX_W-1:0] push_data;
  logic [COL_W-1:0] col;
  logic [NPATH-1:0][PIX_W-1:0] level;
  logic [NPATH-1:0] short_flags;
  logic [PIX_W-1:0] cur_level;
  logic [PIX_W:0] add_sum;
  logic [PIX_W-1:0] off_ext;
  logic [PIX_W-1:0] corr;

  // ==========================================================
  // Dark row sequencing
  assign in_dark = (q.st == ST_DARK);
  assign accept = I_PIX_VALID && buf_ready;
  assign col = q.pix_cnt[COL_W-1:0];
  assign last_pix = (q.pix_cnt == q.row_len - 1'b1);
  // A zero row count still yields one row, so a frame never stalls
  assign last_row = (9'(q.row_cnt) + 9'h001 >= 9'(q.rows));
  assign dropping = in_dark && q.gate && (q.row_cnt == 8'h00);
  assign smp_valid = in_dark && accept && !dropping;
  assign fin = in_dark && accept && last_pix && last_row;

  // ==========================================================
  // Pixel correction
  assign cur_level = level[col];
  assign off_ext = PIX_W'(q.off);
  assign add_sum = {1'b0, I_PIX_DATA} + {1'b0, off_ext};

  always_comb
  begin
    if (q.auto_en)
      corr = (I_PIX_DATA < cur_level) ? '0 : I_PIX_DATA - cur_level;
    else if (q.dec)
      corr = (I_PIX_DATA < off_ext) ? '0 : I_PIX_DATA - off_ext;
    else
      corr = add_sum[PIX_W] ? PIX_MAX : add_sum[PIX_W-1:0];
  end

  always_comb
  begin
    push_valid = 1'b0;
    push_data = I_PIX_DATA;
    case (q.st)
      ST_IDLE:
      begin
        push_valid = accept;
        push_data = I_PIX_DATA;
      end
      ST_DARK:
      begin
        // Dropped row is consumed but never forwarded
        push_valid = accept && !dropping;
        push_data = I_PIX_DATA;
      end
      ST_IMAGE:
      begin
        push_valid = accept;
        push_data = corr;
      end
      default:
      begin
        push_valid = 1'b0;
        push_data = I_PIX_DATA;
      end
    endcase
  end

  // ==========================================================
  // Sequencer and register next state
  always_comb
  begin
    d = q;
    d.row_go = 1'b0;
    if (I_REG_WR)
    begin
      case (I_REG_ADDR)
        ADDR_ROW_CFG:
        begin
          d.rows = I_REG_WDATA[ROWS_LSB +: 8];
          d.gate = I_REG_WDATA[GATE_BIT];
        end
        ADDR_FILTER_CFG:
          d.depth = I_REG_WDATA[DEPTH_LSB +: 3];
        ADDR_OFFSET_CTRL:
        begin
          d.auto_en = I_REG_WDATA[AUTO_BIT];
          d.off = I_REG_WDATA[OFF_LSB +: 9];
          d.dec = I_REG_WDATA[DEC_BIT];
        end
        default:
          d.rows = q.rows;
      endcase
    end
    if (I_REG_RD)
    begin
      case (I_REG_ADDR)
        ADDR_ROW_CFG:
          d.rdata = REG_W'({q.gate, q.rows});
        ADDR_FILTER_CFG:
          d.rdata = REG_W'({q.depth, 8'h00});
        ADDR_OFFSET_CTRL:
          d.rdata = REG_W'({q.dec, q.off, q.auto_en});
        ADDR_SHORT_STAT:
          d.rdata = REG_W'(short_flags);
        default:
          d.rdata = '0;
      endcase
    end
    case (q.st)
      ST_IDLE, ST_IMAGE:
      begin
        if (accept)
          d.pix_cnt = q.pix_cnt + 1'b1;
      end
      ST_DARK:
      begin
        if (accept)
        begin
          if (last_pix)
          begin
            d.pix_cnt = '0;
            d.row_cnt = q.row_cnt + 1'b1;
            if (last_row)
              d.st = ST_IMAGE;
            else
              d.row_go = 1'b1;
          end
          else
            d.pix_cnt = q.pix_cnt + 1'b1;
        end
      end
      default:
        d.st = ST_IDLE;
    endcase
    // A new frame restarts the dark phase from any state
    if (I_FRAME_START)
    begin
      d.st = ST_DARK;
      d.row_cnt = '0;
      d.pix_cnt = '0;
      d.row_go = 1'b1;
      if (I_ROLLING)
        d.row_len = {I_LINE_KERNELS, 3'b000};
      else
        d.row_len = {GS_KERNELS, 3'b000};
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.row_len <= {GS_KERNELS, 3'b000};
      q.rows <= RST_ROWS;
      q.gate <= RST_GATE;
      q.depth <= RST_DEPTH;
      q.auto_en <= RST_AUTO;
      q.off <= RST_OFF;
      q.dec <= RST_DEC;
    end
    else
      q <= d;
  end

  // ==========================================================
  // Submodules
  blc_filter #(
    .NP(NPATH)
  ) blc_filter_inst (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_clr(I_FRAME_START),
    .i_fin(fin),
    .i_depth(q.depth),
    .i_smp_valid(smp_valid && q.auto_en),
    .i_smp_col(col),
    .i_smp_data(I_PIX_DATA),
    .o_level(level),
    .o_short(short_flags)
  );

  blc_fifo #(
    .WIDTH(OW),
    .DEPTH(2)
  ) blc_fifo_inst (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_valid(push_valid),
    .i_data({in_dark, push_data}),
    .o_ready(buf_ready),
    .o_valid(O_PIX_VALID),
    .o_data({O_PIX_DARK, O_PIX_DATA}),
    .i_ready(I_PIX_READY)
  );

  assign O_PIX_READY = buf_ready;
  assign O_DARK_ACTIVE = in_dark;
  assign O_DARK_ROW_START = q.row_go;
  assign O_REG_RDATA = q.rdata;

  // ==========================================================
  // Checks
  a_frame_dark: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_FRAME_START |=> q.st == ST_DARK && q.row_cnt == 8'h00)
    else $error("frame start did not enter dark phase");
  a_dark_rows_done: assert property (@(posedge I_MCLK) disable iff (I_RST)
    q.st == ST_DARK && d.st == ST_IMAGE |-> 9'(q.row_cnt) + 9'h001 >= 9'(q.rows))
    else $error("dark phase ended early");
  a_gs_row_len: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_FRAME_START && !I_ROLLING |=> q.row_len == {GS_KERNELS, 3'b000})
    else $error("global shutter dark row length wrong");
  a_rs_row_len: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_FRAME_START && I_ROLLING |=> q.row_len == {$past(I_LINE_KERNELS), 3'b000})
    else $error("rolling shutter dark row length wrong");
  a_drop_first: assert property (@(posedge I_MCLK) disable iff (I_RST)
    in_dark && q.gate && q.row_cnt == 8'h00 |-> !push_valid && !smp_valid)
    else $error("first dark row not blanked");
  a_dark_raw: assert property (@(posedge I_MCLK) disable iff (I_RST)
    in_dark && push_valid |-> push_data == I_PIX_DATA)
    else $error("dark pixel altered");
  a_manual_add: assert property (@(posedge I_MCLK) disable iff (I_RST)
    q.st == ST_IMAGE && !q.auto_en && !q.dec && push_valid && add_sum <= 11'h3FF
    |-> push_data == I_PIX_DATA + off_ext)
    else $error("manual add offset wrong");
  a_manual_sub: assert property (@(posedge I_MCLK) disable iff (I_RST)
    q.st == ST_IMAGE && !q.auto_en && q.dec && push_valid && I_PIX_DATA >= off_ext
    |-> push_data == I_PIX_DATA - off_ext)
    else $error("manual subtract offset wrong");
  a_auto_ignores_sign: assert property (@(posedge I_MCLK) disable iff (I_RST)
    q.st == ST_IMAGE && q.auto_en && push_valid && I_PIX_DATA >= level[col]
    |-> push_data == I_PIX_DATA - level[col])
    else $error("auto correction wrong");
  a_status_read: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_REG_RD && I_REG_ADDR == ADDR_SHORT_STAT |=> O_REG_RDATA[7:0] == $past(short_flags))
    else $error("shortfall status read wrong");
endmodule
`default_nettype wire

// ===== pkg/blc_pkg.sv
// Constants, types and register map of the black-level calibration block
//
// Overview of operation
// - Emit the programmed number of dark rows at the start of every frame.
// - Global shutter: each dark row holds 160 kernels of dark pixels.
// - Rolling shutter: dark row length equals the active window line length.
// - With the drop bit set, blank the first dark row and skip its samples.
// - Auto mode: derive offset from dark samples and apply to every image pixel.
// - Manual mode: stop auto calibration and apply the programmed offset.
// - Dark sample pixels leave raw, uncorrected, in both modes.
// - Manual mode uses the nine-bit offset magnitude as the correction.
// - Sign bit zero adds the manual offset, one subtracts it.
// - The sign bit is ignored while auto calibration is enabled.
// - Manual mode applies one identical offset to all paths.
// - Dark samples are low-pass filtered; depth set by a three-bit field.
// - Samples averaged equal two to the power of the depth field.
// - Per-path read-only flag set when a path lacks the requested samples.
// - A flagged path's compensation is not guaranteed; software must react.
// - Calibration runs once per frame on that frame's dark rows.
// - The black level is computed separately for the 8 kernel columns.
`default_nettype none
package blc_pkg;
  localparam int PIX_W = 10;
  localparam int NPATH = 8;
  localparam int COL_W = 3;
  localparam int SUM_W = 17;
  localparam int CNT_W = 9;
  localparam int ADDR_W = 9;
  localparam int REG_W = 16;
  localparam int PCNT_W = 11;
  localparam logic [PIX_W-1:0] PIX_MAX = 10'h3FF;
  localparam logic [7:0] GS_KERNELS = 8'hA0;
  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_FILTER_CFG = 9'h080;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_CTRL = 9'h081;
  localparam logic [ADDR_W-1:0] ADDR_SHORT_STAT = 9'h088;
  localparam logic [ADDR_W-1:0] ADDR_ROW_CFG = 9'h0C5;
  // Field positions
  localparam int ROWS_LSB = 0;
  localparam int GATE_BIT = 8;
  localparam int DEPTH_LSB = 8;
  localparam int AUTO_BIT = 0;
  localparam int OFF_LSB = 1;
  localparam int DEC_BIT = 10;
  // Reset values
  localparam logic [7:0] RST_ROWS = 8'h08;
  localparam logic RST_GATE = 1'b1;
  localparam logic [2:0] RST_DEPTH = 3'h3;
  localparam logic RST_AUTO = 1'b1;
  localparam logic [8:0] RST_OFF = 9'h000;
  localparam logic RST_DEC = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DARK = 2'b01,
    ST_IMAGE = 2'b10
  } blc_state_t;
endpackage
`default_nettype wire

// ===== tb/blc_host_sink.sv
// Host-side pixel sink that records the output stream and can stall it
`timescale 1ns/10ps
`default_nettype none
module blc_host_sink (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Stall mode: ready only every other cycle
  input wire logic i_slow,
  // Pixel stream from the block
  input wire logic i_valid,
  input wire logic [blc_pkg::PIX_W-1:0] i_data,
  input wire logic i_dark,
  output logic o_ready
);
  import blc_pkg::*;
  logic [PIX_W:0] got[$];
  logic phase_q;
  // Ready moves only just after an edge, so a stall never splits a word
  assign o_ready = !i_rst && (!i_slow || phase_q);
  always @(posedge i_clk or posedge i_rst)
    if (i_rst)
      phase_q <= 1'b0;
    else
    begin
      if (i_valid && o_ready)
        got.push_back({i_dark, i_data});
      phase_q <= ~phase_q;
    end
endmodule
`default_nettype wire

// ===== tb/blc_top_tb.sv
// Self-checking bench for the black-level calibration block
`timescale 1ns/10ps
`default_nettype none
module blc_top_tb;
  import blc_pkg::*;
  logic I_MCLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_REG_WR = 1'b0;
  logic I_REG_RD = 1'b0;
  logic [ADDR_W-1:0] I_REG_ADDR = '0;
  logic [REG_W-1:0] I_REG_WDATA = '0;
  logic [REG_W-1:0] O_REG_RDATA;
  logic I_FRAME_START = 1'b0;
  logic I_ROLLING = 1'b0;
  logic [7:0] I_LINE_KERNELS = 8'h00;
  logic O_DARK_ACTIVE;
  logic O_DARK_ROW_START;
  logic I_PIX_VALID = 1'b0;
  logic [PIX_W-1:0] I_PIX_DATA = '0;
  logic O_PIX_READY;
  logic O_PIX_VALID;
  logic [PIX_W-1:0] O_PIX_DATA;
  logic O_PIX_DARK;
  logic I_PIX_READY;
  logic slow = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int rs_cnt = 0;

  blc_top blc_top_inst (
    .I_MCLK(I_MCLK),
    .I_RST(I_RST),
    .I_REG_WR(I_REG_WR),
    .I_REG_RD(I_REG_RD),
    .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA),
    .O_REG_RDATA(O_REG_RDATA),
    .I_FRAME_START(I_FRAME_START),
    .I_ROLLING(I_ROLLING),
    .I_LINE_KERNELS(I_LINE_KERNELS),
    .O_DARK_ACTIVE(O_DARK_ACTIVE),
    .O_DARK_ROW_START(O_DARK_ROW_START),
    .I_PIX_VALID(I_PIX_VALID),
    .I_PIX_DATA(I_PIX_DATA),
    .O_PIX_READY(O_PIX_READY),
    .O_PIX_VALID(O_PIX_VALID),
    .O_PIX_DATA(O_PIX_DATA),
    .O_PIX_DARK(O_PIX_DARK),
    .I_PIX_READY(I_PIX_READY)
  );

  blc_host_sink blc_host_sink_inst (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_slow(slow),
    .i_valid(O_PIX_VALID),
    .i_data(O_PIX_DATA),
    .i_dark(O_PIX_DARK),
    .o_ready(I_PIX_READY)
  );

  always #50 I_MCLK = ~I_MCLK;

  // Hang guard; a full run needs about 1700 cycles
  always @(posedge I_MCLK)
  begin
    cyc++;
    if (O_DARK_ROW_START === 1'b1)
      rs_cnt++;
    if (cyc == 20000)
    begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // Drivers and compares (all enter and leave on a falling edge)
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_pix(input logic [PIX_W:0] g, input logic [PIX_W:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(negedge I_MCLK);
    I_REG_WR = 1'b1;
    I_REG_ADDR = a;
    I_REG_WDATA = d;
    @(negedge I_MCLK);
    I_REG_WR = 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    @(negedge I_MCLK);
    I_REG_RD = 1'b1;
    I_REG_ADDR = a;
    @(negedge I_MCLK);
    I_REG_RD = 1'b0;
    chk_reg(O_REG_RDATA, e);
  endtask

  // Ramp adds 2 per column and 4 per kernel, giving each column its own level
  task automatic send(input int n, input int base, input int k0, input bit ramp);
    int w;
    @(negedge I_MCLK);
    for (int i = 0; i < n; i++)
    begin
      I_PIX_VALID = 1'b1;
      I_PIX_DATA = ramp ? PIX_W'(base + 2 * ((k0 + i) % 8) + 4 * ((k0 + i) / 8)) : PIX_W'(base);
      w = 0;
      while (O_PIX_READY !== 1'b1 && w < 100)
      begin
        @(negedge I_MCLK);
        w++;
      end
      @(negedge I_MCLK);
    end
    I_PIX_VALID = 1'b0;
  endtask

  task automatic wait_got(input int n);
    int w;
    w = 0;
    while (blc_host_sink_inst.got.size() < n && w < 3000)
    begin
      @(negedge I_MCLK);
      w++;
    end
    chk_reg(16'(blc_host_sink_inst.got.size()), 16'(n));
  endtask

  task automatic run_frame(input bit rol, input int kern, input int n, input bit gate);
    int len;
    int rem;
    int rs0;
    len = rol ? kern * 8 : 1280;
    rem = (n - gate) * len;
    I_ROLLING = rol;
    I_LINE_KERNELS = 8'(kern);
    reg_wr(ADDR_ROW_CFG, {7'h00, gate, 8'(n)});
    blc_host_sink_inst.got.delete();
    rs0 = rs_cnt;
    @(negedge I_MCLK);
    I_FRAME_START = 1'b1;
    @(negedge I_MCLK);
    I_FRAME_START = 1'b0;
    if (gate)
      send(len, 999, 0, 1'b0);
    send(rem - 1, 40, 0, 1'b1);
    chk_reg(16'(O_DARK_ACTIVE), 16'h0001);
    send(1, 40, rem - 1, 1'b1);
    @(negedge I_MCLK);
    chk_reg(16'(O_DARK_ACTIVE), 16'h0000);
    chk_reg(16'(rs_cnt - rs0), 16'(n));
    wait_got(rem);
    for (int i = 0; i < rem; i++)
      chk_pix(blc_host_sink_inst.got[i], {1'b1, PIX_W'(40 + 2 * (i % 8) + 4 * (i / 8))});
  endtask

  task automatic img(input int p, input int sub, input int step);
    int e;
    blc_host_sink_inst.got.delete();
    send(8, p, 0, 1'b0);
    wait_got(8);
    for (int i = 0; i < 8; i++)
    begin
      e = p - sub - step * i;
      e = e < 0 ? 0 : (e > 1023 ? 1023 : e);
      chk_pix(blc_host_sink_inst.got[i], {1'b0, PIX_W'(e)});
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd_chk(ADDR_ROW_CFG, 16'h0108);
    rd_chk(ADDR_FILTER_CFG, 16'h0300);
    rd_chk(ADDR_OFFSET_CTRL, 16'h0001);
    reg_wr(ADDR_SHORT_STAT, 16'hFFFF);
    rd_chk(ADDR_SHORT_STAT, 16'h0000);
    rd_chk(9'h000, 16'h0000);
    reg_wr(ADDR_FILTER_CFG, 16'hFFFF);
    rd_chk(ADDR_FILTER_CFG, 16'h0700);
    $display("test regs done");
  endtask

  // Level per column is 42 + 2c with two samples; sign and offset must be ignored
  task automatic t_auto();
    slow = 1'b1;
    reg_wr(ADDR_FILTER_CFG, 16'h0100);
    reg_wr(ADDR_OFFSET_CTRL, 16'h060B);
    run_frame(1'b1, 2, 3, 1'b1);
    rd_chk(ADDR_SHORT_STAT, 16'h0000);
    img(100, 42, 2);
    img(30, 42, 2);
    slow = 1'b0;
    $display("test auto done");
  endtask

  // One kept row gives two samples a column: eight is short, two is exact
  task automatic t_short();
    reg_wr(ADDR_FILTER_CFG, 16'h0300);
    run_frame(1'b1, 2, 2, 1'b1);
    rd_chk(ADDR_SHORT_STAT, 16'h00FF);
    reg_wr(ADDR_FILTER_CFG, 16'h0100);
    run_frame(1'b1, 2, 2, 1'b1);
    rd_chk(ADDR_SHORT_STAT, 16'h0000);
    $display("test shortfall done");
  endtask

  task automatic t_manual();
    for (int dec = 0; dec < 2; dec++)
    begin
      reg_wr(ADDR_OFFSET_CTRL, dec ? 16'h060A : 16'h020A);
      run_frame(1'b1, 1, 1, 1'b0);
      img(dec ? 300 : 100, dec ? 261 : -261, 0);
      img(dec ? 100 : 1020, dec ? 261 : -261, 0);
    end
    $display("test manual done");
  endtask

  task automatic t_global();
    reg_wr(ADDR_OFFSET_CTRL, 16'h0001);
    reg_wr(ADDR_FILTER_CFG, 16'h0000);
    run_frame(1'b0, 2, 1, 1'b0);
    img(100, 40, 2);
    $display("test global done");
  endtask

  task automatic results();
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge I_MCLK);
    I_RST = 1'b0;
    t_regs();
    t_auto();
    t_short();
    t_manual();
    t_global();
    results();
  end
endmodule
`default_nettype wire
